// ===== imig_pkg.sv
package imig_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] INT_REG_OFS    = 8'h01;
  localparam logic [7:0] STATUS_OFS     = 8'h02;
  localparam logic [7:0] EVT_STAT_OFS   = 8'h03;
  localparam logic [7:0] EVT_CLR_OFS    = 8'h04;
  localparam logic [7:0] EVT_EN_OFS     = 8'h05;
  localparam logic [7:0] CFG_OFS        = 8'h06;
  localparam logic [7:0] SRC_OFS        = 8'h07;
  localparam logic [7:0] RX_ERR_CNT_OFS = 8'h6f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_INIT_BIT   = 0;
  localparam int CTRL_IRQEN_BIT  = 1;
  localparam int ST_BOFF_BIT     = 0;
  localparam int ST_RECOV_BIT    = 1;
  localparam int ST_INIT_BIT     = 2;
  localparam int ST_TXEP_BIT     = 3;
  localparam int RXEC_EP_BIT     = 7;
  localparam int CFG_FREEZE_BIT  = 0;
  localparam int EVT_BOFF_BIT    = 0;
  localparam int EVT_RECOV_BIT   = 1;
  localparam int EVT_SRC_BIT     = 2;
  localparam int EVT_W           = 3;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL_RESET     = 2'h1;
  localparam logic       CFG_RESET      = 1'b1;
  localparam logic [7:0] INT_REG_RESET  = 8'h00;
  localparam int         RECOVERY_COUNT = 129;
  localparam int         EP_LIMIT       = 128;
  localparam int         CLKOUT_DIV     = 2;

endpackage : imig_pkg

// ===== imig_sync2.sv
`timescale 1ns/1ps
module imig_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,  // system clock
  input  wire logic         rst,   // sync reset
  input  wire logic [W-1:0] d,     // asynchronous level
  output logic      [W-1:0] q      // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } imig_sync_t;

  imig_sync_t st_reg;
  imig_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : imig_sync2

// ===== imig_ctrl.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Interrupt register frozen while init set
// - Pin active: nonzero register and enable
// - Init set by reset, write, bus-off
// - Enable clear only gates the pin
// - Clearing init after bus-off starts recovery
// - Recovery counts 129 occurrences before leaving
// - Clock output toggles during reset
// - Error passive flag covers both counters
module imig_ctrl
  import imig_pkg::*;
#(
  parameter int  REC_CNT      = RECOVERY_COUNT,
  parameter int  EP_LVL       = EP_LIMIT,
  parameter bit  OLD_STEPPING = CFG_RESET
) (
  input  wire logic       mclk,          // system clock
  input  wire logic       rst,           // sync reset, active high
  input  wire logic [7:0] addr,          // register address
  input  wire logic [7:0] wdata,         // write data
  input  wire logic       wr,            // write strobe
  input  wire logic       rd,            // read strobe
  output logic      [7:0] rdata,         // read data, cycle after rd
  input  wire logic [7:0] int_source,    // pending source code from core
  input  wire logic       bus_off_evt,   // pin: bus-off entry level
  input  wire logic       recov_occ,     // pin: recovery occurrence level
  input  wire logic [7:0] rx_err_cnt,    // receive error counter
  input  wire logic [7:0] tx_err_cnt,    // transmit error counter
  output logic            irq_pin,       // interrupt pin, active high
  output logic            evt_irq,       // status-event interrupt
  output logic            bus_off_state, // controller in bus-off
  output logic            clk_out        // clock output pin
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {S_RUN, S_BOFF, S_RECOV} imig_state_t;

  typedef struct packed {
    imig_state_t fsm;
    logic        init;
    logic        irq_pin_enable;
    logic        freeze_en;
    logic [7:0]  int_reg;
    logic [7:0]  rec_cnt;
    logic        occ_d;
    logic        boff_d;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_en;
    logic [7:0]  rdata;
    logic        irq_pin;
    logic        evt_irq;
    logic        bus_off;
    logic        clk_out;
  } imig_ctrl_t;

  imig_ctrl_t st_reg;
  imig_ctrl_t st_next;

  logic [1:0] pins_sync;

  imig_sync2 #(.W(2)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({recov_occ, bus_off_evt}),
    .q    (pins_sync)
  );

  wire logic boff_rise = pins_sync[0] & ~st_reg.boff_d;
  wire logic occ_rise  = pins_sync[1] & ~st_reg.occ_d;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] evt_set;
  logic             err_passive;
  logic             wr_ctrl;

  always_comb begin
    st_next        = st_reg;
    evt_set        = '0;
    err_passive    = (32'(rx_err_cnt) >= EP_LVL) || (32'(tx_err_cnt) >= EP_LVL);
    wr_ctrl        = wr && (addr == CTRL_OFS);
    st_next.boff_d = pins_sync[0];
    st_next.occ_d  = pins_sync[1];
    st_next.clk_out = ~st_reg.clk_out;

    if (wr_ctrl) begin
      // Both bits take effect in the same edge
      st_next.init           = wdata[CTRL_INIT_BIT];
      st_next.irq_pin_enable = wdata[CTRL_IRQEN_BIT];
    end
    if (wr && (addr == CFG_OFS)) begin
      st_next.freeze_en = wdata[CFG_FREEZE_BIT];
    end
    if (wr && (addr == EVT_EN_OFS)) begin
      st_next.evt_en = wdata[EVT_W-1:0];
    end

    case (st_reg.fsm)
      S_RUN: begin
        if (boff_rise) begin
          st_next.fsm     = S_BOFF;
          st_next.init    = 1'b1;
          st_next.bus_off = 1'b1;
          evt_set[EVT_BOFF_BIT] = 1'b1;
        end
      end
      S_BOFF: begin
        if (!st_next.init) begin
          st_next.fsm     = S_RECOV;
          st_next.rec_cnt = '0;
        end
      end
      S_RECOV: begin
        if (occ_rise) begin
          if (32'(st_reg.rec_cnt) == REC_CNT - 1) begin
            st_next.fsm     = S_RUN;
            st_next.bus_off = 1'b0;
            evt_set[EVT_RECOV_BIT] = 1'b1;
          end else begin
            st_next.rec_cnt = st_reg.rec_cnt + 8'h01;
          end
        end
      end
      default: begin
        st_next.fsm = S_RUN;
      end
    endcase

    // Older steppings hold the register while init is set
    if (!(st_reg.freeze_en && st_reg.init)) begin
      st_next.int_reg = int_source;
      if (int_source != st_reg.int_reg && int_source != INT_REG_RESET) begin
        evt_set[EVT_SRC_BIT] = 1'b1;
      end
    end

    // Set wins over clear
    if (wr && (addr == EVT_CLR_OFS)) begin
      st_next.evt_stat = st_reg.evt_stat & ~wdata[EVT_W-1:0];
    end
    st_next.evt_stat = st_next.evt_stat | evt_set;

    st_next.irq_pin = (st_next.int_reg != INT_REG_RESET) && st_next.irq_pin_enable;
    st_next.evt_irq = |(st_next.evt_stat & st_next.evt_en);

    st_next.rdata = 8'h00;
    if (rd) begin
      case (addr)
        CTRL_OFS:       st_next.rdata = {6'h00, st_reg.irq_pin_enable, st_reg.init};
        INT_REG_OFS:    st_next.rdata = st_reg.int_reg;
        STATUS_OFS:     st_next.rdata = {4'h0, (32'(tx_err_cnt) >= EP_LVL), st_reg.init,
                                         (st_reg.fsm == S_RECOV), st_reg.bus_off};
        EVT_STAT_OFS:   st_next.rdata = {5'h00, st_reg.evt_stat};
        EVT_EN_OFS:     st_next.rdata = {5'h00, st_reg.evt_en};
        CFG_OFS:        st_next.rdata = {7'h00, st_reg.freeze_en};
        SRC_OFS:        st_next.rdata = int_source;
        RX_ERR_CNT_OFS: st_next.rdata = {err_passive, rx_err_cnt[6:0]};
        default:        st_next.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg                <= '0;
      st_reg.fsm            <= S_RUN;
      st_reg.init           <= CTRL_RESET[CTRL_INIT_BIT];
      st_reg.irq_pin_enable <= CTRL_RESET[CTRL_IRQEN_BIT];
      st_reg.freeze_en      <= OLD_STEPPING;
      st_reg.int_reg        <= INT_REG_RESET;
      // Keeps toggling in reset and leaves an unknown start level at once
      if (st_reg.clk_out) begin
        st_reg.clk_out <= 1'b0;
      end else begin
        st_reg.clk_out <= 1'b1;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata         = st_reg.rdata;
  assign irq_pin       = st_reg.irq_pin;
  assign evt_irq       = st_reg.evt_irq;
  assign bus_off_state = st_reg.bus_off;
  assign clk_out       = st_reg.clk_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  frozen_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg.freeze_en && st_reg.init && $past(st_reg.init)) |-> $stable(st_reg.int_reg))
    else $error("interrupt register changed while frozen");

  pin_level_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 (irq_pin == (($past(st_next.int_reg) != 8'h00) && $past(st_next.irq_pin_enable))))
    else $error("interrupt pin level wrong");

  boff_init_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg.fsm == S_RUN && boff_rise) |=> (st_reg.init && bus_off_state))
    else $error("bus-off did not set init");

  write_init_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_ctrl && st_reg.fsm != S_RUN) |=> (st_reg.init == $past(wdata[0]) &&
      st_reg.irq_pin_enable == $past(wdata[1])))
    else $error("control write not applied in one cycle");

  en_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_ctrl && !wdata[1] && !(st_reg.freeze_en && st_reg.init)) |=>
      (!irq_pin && st_reg.int_reg == $past(int_source)))
    else $error("enable clear did not only gate pin");

  recov_start_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg.fsm == S_BOFF && !st_next.init) |=> (st_reg.fsm == S_RECOV && st_reg.rec_cnt == 8'h00))
    else $error("recovery not started");

  recov_end_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg.fsm == S_RECOV && occ_rise && 32'(st_reg.rec_cnt) == REC_CNT - 1) |=> !bus_off_state)
    else $error("recovery did not end at count");

  recov_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg.fsm == S_RECOV && !(occ_rise && 32'(st_reg.rec_cnt) == REC_CNT - 1)) |=> bus_off_state)
    else $error("left bus-off early");

  clk_toggle_a: assert property (@(posedge mclk)
    ##2 (clk_out != $past(clk_out)))
    else $error("clock output stopped");

  ep_flag_a: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == 8'h6f && tx_err_cnt >= 8'd128) |=> rdata[7])
    else $error("error passive flag missed transmit counter");

endmodule : imig_ctrl

// ===== imig_can_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------
// Bus side: bus-off entry and recovery occurrences
// ---------------------------------------------------
module imig_can_model (
  input  wire logic mclk,        // system clock
  output logic      bus_off_evt, // bus-off entry level
  output logic      recov_occ    // recovery occurrence level
);
  initial begin
    bus_off_evt = 1'b0;
    recov_occ   = 1'b0;
  end
  task automatic enter_boff();
    @(posedge mclk) bus_off_evt <= 1'b1;
    repeat (4) @(posedge mclk);
    bus_off_evt <= 1'b0;
  endtask : enter_boff
  // Each occurrence held long enough for the two-flop sync
  task automatic occur(input int n);
    repeat (n) begin
      @(posedge mclk) recov_occ <= 1'b1;
      repeat (3) @(posedge mclk);
      recov_occ <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : occur
endmodule : imig_can_model

// ===== tb.sv
`timescale 1ns/1ps
module tb
  import imig_pkg::*;
;
  localparam int REC = 3;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] int_source = 8'h00;
  logic [7:0] rx_err_cnt = 8'h00;
  logic [7:0] tx_err_cnt = 8'h00;
  logic       bus_off_evt, recov_occ, irq_pin, evt_irq, bus_off_state, clk_out;
  int         fail_count = 0;
  int         n_tests = 0;
  logic [7:0] d;
  logic       c0;

  always #5 mclk = ~mclk;

  imig_ctrl #(.REC_CNT(REC)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .int_source(int_source), .bus_off_evt(bus_off_evt), .recov_occ(recov_occ),
    .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt), .irq_pin(irq_pin), .evt_irq(evt_irq),
    .bus_off_state(bus_off_state), .clk_out(clk_out));
  imig_can_model can (.mclk(mclk), .bus_off_evt(bus_off_evt), .recov_occ(recov_occ));

  // ---------------------------------------------------
  // Bus cycles and checks
  // ---------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  // ---------------------------------------------------
  // Scenarios
  // ---------------------------------------------------
  task automatic t_reset();
    rd_reg(CTRL_OFS, d); chk("ctrl reset", 8'h01, d);
    rd_reg(INT_REG_OFS, d); chk("int reg reset", INT_REG_RESET, d);
    rd_reg(8'h40, d); chk("unmapped read", 8'h00, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_freeze();
    wr_reg(CTRL_OFS, 8'h02);
    int_source <= 8'h05;
    wait_cyc(3);
    rd_reg(INT_REG_OFS, d); chk("int reg live", 8'h05, d);
    chk("pin on", 8'h01, {7'h0, irq_pin});
    wr_reg(CTRL_OFS, 8'h01);
    int_source <= 8'h09;
    wait_cyc(2);
    chk("pin gated", 8'h00, {7'h0, irq_pin});
    rd_reg(INT_REG_OFS, d); chk("int reg frozen", 8'h05, d);
    wr_reg(CTRL_OFS, 8'h03);
    wait_cyc(2);
    chk("pin frozen nonzero", 8'h01, {7'h0, irq_pin});
    wr_reg(CTRL_OFS, 8'h02);
    wait_cyc(2);
    rd_reg(INT_REG_OFS, d); chk("int reg after init", 8'h09, d);
    int_source <= 8'h00;
    wait_cyc(2);
    chk("pin zero reg", 8'h00, {7'h0, irq_pin});
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_boff();
    wr_reg(EVT_CLR_OFS, 8'h07);
    wr_reg(EVT_EN_OFS, 8'h01);
    can.enter_boff();
    wait_cyc(2);
    chk("bus off", 8'h01, {7'h0, bus_off_state});
    chk("event irq", 8'h01, {7'h0, evt_irq});
    rd_reg(CTRL_OFS, d); chk("init by bus off", 8'h01, d[0]);
    wr_reg(EVT_CLR_OFS, 8'h01);
    wait_cyc(2);
    chk("event cleared", 8'h00, {7'h0, evt_irq});
    wr_reg(CTRL_OFS, 8'h02);
    wait_cyc(2);
    rd_reg(STATUS_OFS, d); chk("recovering", 8'h01, d[ST_RECOV_BIT]);
    can.occur(REC - 1);
    wait_cyc(4);
    chk("still bus off", 8'h01, {7'h0, bus_off_state});
    can.occur(1);
    wait_cyc(1);
    chk("bus on", 8'h00, {7'h0, bus_off_state});
    $display("test bus off done");
  endtask : t_boff
  task automatic t_ep();
    rx_err_cnt <= 8'h05;
    tx_err_cnt <= 8'h80;
    rd_reg(RX_ERR_CNT_OFS, d); chk("ep by tx", 8'h85, d);
    tx_err_cnt <= 8'h7f;
    rd_reg(RX_ERR_CNT_OFS, d); chk("ep clear", 8'h05, d);
    $display("test error passive done");
  endtask : t_ep

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    wait_cyc(3);
    c0 = clk_out;
    wait_cyc(1);
    chk("clock out in reset", {7'h0, ~c0}, {7'h0, clk_out});
    @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_freeze();
    t_boff();
    t_ep();
    tally_and_finish();
  end
endmodule : tb
